// ---- hw/afd_core.sv ----
// Notes on behaviour
// - Result buffer holds sixteen ADC results plus one separate temperature result.
// - Full buffer overwrites its oldest ADC result with the newest.
// - ADC word: four zeros, ten result bits MSB first, two sub-bits.
// - Each chip-select fall presents the oldest unread word, MSB first.
// - Empty buffer reads out as all zeros.
// - First word after a temperature measurement is four zeros plus twelve-bit temperature.
// - Unread temperature result is replaced by a newer one.
// - Temperature is two's complement Celsius, eight steps per degree.
// - DAC codes are straight binary, zero lowest, all ones highest.
// - Sixteen-bit serial DAC word becomes parallel input-register data.
// - Host lowers chip select; device samples input on falling serial clock.
// - DAC write: command 0001xxxx, then two bytes of channel and data.
// - Eight channels each have an input register and a ten-bit output register.
// - Load strobe low or load command copies input to output registers.
// - Wake select low: codes 000h, buffers off, outputs pulled to ground.
// - Wake select high: codes 3FFh, buffers off, outputs pulled to reference.
// - Large variant twelve lines in three groups; small variant four lines.
// - GPIO write: command then one data byte (small) or two (large).
// - Internal oscillator runs and times conversions in modes 00, 01, 10.
// - Mode 11 times conversions from the serial clock, 0.1 to 3.6 MHz.
// - External track-and-hold timing only in clock mode 01.
// - Internally timed modes allow readout at serial clocks up to 25 MHz.
// - Setup byte bits 5:4 pick clock mode; mode 10 after reset.
// - End-of-conversion low on completion, high on selects falling, high in mode 11.
// - Chip select high returns the interface idle, dropping partial frames.

module afd_result_fifo #(
  parameter int WIDTH     = 12,
  parameter int DEPTH     = 4,
  parameter bit OVERWRITE = 1'b0
) (
  input  wire logic             core_clk,   // Core clock
  input  wire logic             resetn,     // Async reset, active low
  input  wire logic             inValid,    // Write request
  input  wire logic [WIDTH-1:0] inData,     // Write data
  output logic                  inReady,    // Space available
  output logic                  outValid,   // Data available
  output logic      [WIDTH-1:0] outData,    // Oldest entry
  input  wire logic             outReady    // Read accept
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wrPtr_r;
  logic [AW-1:0]    rdPtr_r;
  logic [AW:0]      count_r;
  logic [AW:0]      count_nxt;
  logic             full_r;
  logic             empty_r;
  logic             room_r;
  logic             push;
  logic             pop;
  logic             drop;

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
    $error("afd_result_fifo depth must be a power of two");
  end

  // Registered so the ready port comes straight from a flip-flop
  assign inReady  = room_r;
  assign outValid = ~empty_r;
  assign outData  = mem[rdPtr_r];
  assign push     = inValid & inReady;
  assign pop      = outValid & outReady;
  // Overwrite keeps the newest results; losing old data beats stalling the ADC
  assign drop     = push & full_r & ~pop;

  always_comb begin
    count_nxt = count_r;
    if (push && !pop && !drop) begin
      count_nxt = count_r + 1'b1;
    end else if (pop && !push) begin
      count_nxt = count_r - 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (push) begin
      mem[wrPtr_r] <= inData;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
      count_r <= '0;
      full_r  <= 1'b0;
      empty_r <= 1'b1;
      room_r  <= 1'b1;
    end else begin
      if (push) begin
        wrPtr_r <= wrPtr_r + 1'b1;
      end
      if (pop || drop) begin
        rdPtr_r <= rdPtr_r + 1'b1;
      end
      count_r <= count_nxt;
      full_r  <= (count_nxt == (AW+1)'(DEPTH));
      empty_r <= (count_nxt == '0);
      room_r  <= OVERWRITE | (count_nxt != (AW+1)'(DEPTH));
    end
  end

endmodule

module afd_core #(
  parameter int GPIO_LINES = afd_pkg::GPIO_LINES
) (
  input  wire logic        core_clk,           // 125 MHz core clock
  input  wire logic        resetn,             // Async reset, active low
  input  wire logic        cs_n,               // Serial chip select pin
  input  wire logic        sclk,               // Serial clock pin
  input  wire logic        din,                // Serial data in pin
  output logic             dout,               // Serial data out
  input  wire logic        dac_load_strobe_n,  // DAC load pin
  input  wire logic        convert_start_n,    // Convert start pin
  input  wire logic        dac_wake_select,    // DAC wake-up strap
  input  wire logic        conv_valid,         // ADC result strobe
  input  wire logic [11:0] conv_result,        // Result and sub-bits
  output logic             conv_ready,         // Staging space free
  input  wire logic        temp_valid,         // Temperature strobe
  input  wire logic [11:0] temp_result,        // Temperature code
  input  wire logic        ops_done,           // Last operation done
  output logic             eoc_n,              // End of conversion
  output logic [79:0]      dac_code,           // Eight output codes
  output logic [7:0]       dac_buf_off,        // Buffers powered down
  output logic             dac_pull_ref,       // Pull to reference
  output logic [3:0]       gpio_group_a,       // GPIO group A
  output logic [3:0]       gpio_group_b,       // GPIO group B
  output logic [3:0]       gpio_group_c,       // GPIO group C
  output logic             clock_mode_sel_hi,  // Clock mode bit 1
  output logic             clock_mode_sel_lo,  // Clock mode bit 0
  output logic             int_osc_en,         // Internal oscillator on
  output logic             ext_th_en,          // External track-hold
  output logic             sclk_conv_tick      // Serial-clock conv tick
);
  localparam int NCH = afd_pkg::DAC_CHANNELS;
  localparam logic [4:0] GPIO_LAST =
    (GPIO_LINES == 12) ? afd_pkg::LAST_LONG_BIT : afd_pkg::LAST_SHORT_BIT;

  if (GPIO_LINES != 12 && GPIO_LINES != 4) begin : g_chk
    $error("afd_core supports 4 or 12 GPIO lines");
  end

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic [5:0] pinS1_r;
  logic [5:0] pinS2_r;
  logic [5:0] pinS3_r;
  logic       csS2;
  logic       sclkS2;
  logic       dinS2;
  logic       csFall;
  logic       sclkFall;
  logic       sclkRise;
  logic       ldFall;
  logic       cnvFall;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      // Serial clock idles low; a reset value of one would fake a fall
      pinS1_r <= 6'h3d;
      pinS2_r <= 6'h3d;
      pinS3_r <= 6'h3d;
    end else begin
      pinS1_r <= {dac_wake_select, convert_start_n, dac_load_strobe_n, din, sclk, cs_n};
      pinS2_r <= pinS1_r;
      pinS3_r <= pinS2_r;
    end
  end

  assign csS2     = pinS2_r[0];
  assign sclkS2   = pinS2_r[1];
  assign dinS2    = pinS2_r[2];
  assign csFall   = pinS3_r[0] & ~csS2;
  // Sampling at 125 MHz leaves two and a half core cycles per half period at 25 MHz
  assign sclkFall = pinS3_r[1] & ~sclkS2 & ~csS2;
  assign sclkRise = ~pinS3_r[1] & sclkS2;
  assign ldFall   = pinS3_r[3] & ~pinS2_r[3];
  assign cnvFall  = pinS3_r[4] & ~pinS2_r[4];

  // ****************************************************************
  // Serial frame receiver
  // ****************************************************************
  afd_pkg::afd_frame_t frame_r;
  logic [4:0]          bitCnt_r;
  logic [15:0]         rx_r;
  logic [15:0]         rxNext;
  logic                cmdStb;
  logic                dacStb;
  logic                gpioStb;

  assign rxNext  = {rx_r[14:0], dinS2};
  assign cmdStb  = sclkFall && frame_r == afd_pkg::FR_CMD && bitCnt_r == afd_pkg::LAST_CMD_BIT;
  assign dacStb  = sclkFall && frame_r == afd_pkg::FR_DAC && bitCnt_r == afd_pkg::LAST_LONG_BIT;
  assign gpioStb = sclkFall && frame_r == afd_pkg::FR_GPIO && bitCnt_r == GPIO_LAST;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      frame_r  <= afd_pkg::FR_CMD;
      bitCnt_r <= '0;
      rx_r     <= '0;
    end else if (csS2) begin
      frame_r  <= afd_pkg::FR_CMD;
      bitCnt_r <= '0;
      rx_r     <= '0;
    end else if (sclkFall) begin
      rx_r <= rxNext;
      if (bitCnt_r != afd_pkg::BIT_CNT_MAX) begin
        bitCnt_r <= bitCnt_r + 1'b1;
      end
      if (cmdStb) begin
        if (rxNext[7:4] == afd_pkg::CMD_DAC_NIBBLE) begin
          frame_r <= afd_pkg::FR_DAC;
        end else if (rxNext[7:0] == afd_pkg::CMD_GPIO_WRITE) begin
          frame_r <= afd_pkg::FR_GPIO;
        end else begin
          frame_r <= afd_pkg::FR_IGNORE;
        end
      end else if (dacStb || gpioStb) begin
        frame_r <= afd_pkg::FR_IGNORE;
      end
    end
  end

  // ****************************************************************
  // Setup register: clock mode
  // ****************************************************************
  logic [1:0] mode_r;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      mode_r <= afd_pkg::CKM_RESET;
    end else if (cmdStb && rxNext[7:6] == afd_pkg::CMD_SETUP_TOP) begin
      mode_r <= rxNext[afd_pkg::CKM_POS +: 2];
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      int_osc_en     <= 1'b1;
      ext_th_en      <= 1'b0;
      sclk_conv_tick <= 1'b0;
    end else begin
      int_osc_en     <= (mode_r != afd_pkg::CKM_SCLK);
      ext_th_en      <= (mode_r == afd_pkg::CKM_CONVERT_START_N_TH);
      // Host keeps the serial clock within 0.1 to 3.6 MHz in this mode
      sclk_conv_tick <= (mode_r == afd_pkg::CKM_SCLK) && sclkRise;
    end
  end

  assign clock_mode_sel_hi = mode_r[1];
  assign clock_mode_sel_lo = mode_r[0];

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      eoc_n <= 1'b1;
    end else if (mode_r == afd_pkg::CKM_SCLK) begin
      eoc_n <= 1'b1;
    end else if (ops_done) begin
      eoc_n <= 1'b0;
    end else if (csFall || cnvFall) begin
      eoc_n <= 1'b1;
    end
  end

  // ****************************************************************
  // Result path: staging FIFO, result buffer, temperature slot
  // ****************************************************************
  logic        stageValid;
  logic [11:0] stageData;
  logic        stageTake;
  logic        resValid;
  logic [11:0] resData;
  logic        resPop;
  logic        tempValid_r;
  logic [11:0] tempReg_r;
  logic [15:0] txWord_r;
  logic [15:0] pick;

  // Drain stalls on readout so the result buffer never pushes and pops at once
  assign stageTake = ~csFall;

  afd_result_fifo #(.WIDTH(12), .DEPTH(afd_pkg::STAGE_DEPTH), .OVERWRITE(1'b0)) u_stage (
    .core_clk (core_clk),
    .resetn   (resetn),
    .inValid  (conv_valid),
    .inData   (conv_result),
    .inReady  (conv_ready),
    .outValid (stageValid),
    .outData  (stageData),
    .outReady (stageTake)
  );

  afd_result_fifo #(.WIDTH(12), .DEPTH(afd_pkg::RESULT_DEPTH), .OVERWRITE(1'b1)) u_result (
    .core_clk (core_clk),
    .resetn   (resetn),
    .inValid  (stageValid & stageTake),
    .inData   (stageData),
    .inReady  (),
    .outValid (resValid),
    .outData  (resData),
    .outReady (resPop)
  );

  // Sign and scale of the temperature code pass through untouched
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      tempValid_r <= 1'b0;
      tempReg_r   <= '0;
    end else if (temp_valid) begin
      tempValid_r <= 1'b1;
      tempReg_r   <= temp_result;
    end else if (csFall) begin
      tempValid_r <= 1'b0;
    end
  end

  assign resPop = csFall & ~tempValid_r & resValid;

  always_comb begin
    if (tempValid_r) begin
      pick = {4'h0, tempReg_r};
    end else if (resValid) begin
      pick = {4'h0, resData};
    end else begin
      pick = 16'h0000;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      txWord_r <= '0;
      dout     <= 1'b0;
    end else if (csFall) begin
      txWord_r <= pick;
      dout     <= pick[15];
    end else if (sclkFall) begin
      txWord_r <= {txWord_r[14:0], 1'b0};
      dout     <= txWord_r[14];
    end
  end

  // ****************************************************************
  // DAC input and output registers
  // ****************************************************************
  logic [9:0] dacIn_r  [NCH];
  logic [9:0] dacOut_r [NCH];
  logic [1:0] initCnt_r;
  logic       initDone_r;
  logic       wakeCatch;
  logic [3:0] dacSel;
  logic [9:0] dacData;
  logic       dacLoad;

  assign wakeCatch = ~initDone_r && initCnt_r == afd_pkg::WAKE_SETTLE;
  assign dacSel    = rxNext[afd_pkg::DAC_SEL_POS +: 4];
  assign dacData   = rxNext[afd_pkg::DAC_DATA_POS +: 10];
  assign dacLoad   = initDone_r && (ldFall || (dacStb && dacSel == afd_pkg::DAC_OP_LOAD));

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      initCnt_r    <= '0;
      initDone_r   <= 1'b0;
      dac_pull_ref <= 1'b0;
    end else if (!initDone_r) begin
      initCnt_r <= initCnt_r + 1'b1;
      if (wakeCatch) begin
        initDone_r   <= 1'b1;
        dac_pull_ref <= pinS2_r[5];
      end
    end
  end

  for (genvar ch = 0; ch < NCH; ch++) begin : g_dac
    always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
        dacIn_r[ch]     <= afd_pkg::CODE_ZERO;
        dacOut_r[ch]    <= afd_pkg::CODE_ZERO;
        dac_buf_off[ch] <= 1'b1;
      end else if (wakeCatch) begin
        dacIn_r[ch]  <= pinS2_r[5] ? afd_pkg::CODE_FULL : afd_pkg::CODE_ZERO;
        dacOut_r[ch] <= pinS2_r[5] ? afd_pkg::CODE_FULL : afd_pkg::CODE_ZERO;
      end else begin
        if (dacStb && (dacSel == 4'(ch) || dacSel == afd_pkg::DAC_OP_ALL)) begin
          dacIn_r[ch] <= dacData;
        end
        if (dacLoad) begin
          dacOut_r[ch]    <= dacIn_r[ch];
          dac_buf_off[ch] <= 1'b0;
        end
      end
    end
    // Straight binary: the code drives the converter unchanged
    assign dac_code[ch*10 +: 10] = dacOut_r[ch];
  end

  // ****************************************************************
  // GPIO write
  // ****************************************************************
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      gpio_group_a <= '0;
      gpio_group_b <= '0;
      gpio_group_c <= '0;
    end else if (gpioStb) begin
      if (GPIO_LINES == 12) begin
        gpio_group_a <= rxNext[3:0];
        gpio_group_b <= rxNext[7:4];
        gpio_group_c <= rxNext[11:8];
      end else begin
        gpio_group_a <= {2'h0, rxNext[1:0]};
        gpio_group_c <= {2'h0, rxNext[3:2]};
      end
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  temp_first_a: assert property (csFall && tempValid_r |=> txWord_r == {4'h0, $past(tempReg_r)})
    else $error("temperature word not presented first");
  empty_zero_a: assert property (csFall && !tempValid_r && !resValid |=> txWord_r == 16'h0000 ##1 !dout)
    else $error("empty buffer did not read as zero");
  adc_frame_a: assert property (csFall && !tempValid_r && resValid |=> txWord_r[15:12] == 4'h0 && dout == 1'b0)
    else $error("ADC word lacks leading zeros");
  dout_hold_a: assert property (!csS2 && !csFall && !sclkFall |=> $stable(dout))
    else $error("serial output moved without a clock edge");
  cs_idle_a: assert property (csS2 |=> bitCnt_r == 5'h00 && frame_r == afd_pkg::FR_CMD)
    else $error("chip select high did not idle interface");
  dac_load_a: assert property (dacLoad |=> dacOut_r[3] == $past(dacIn_r[3]) && !dac_buf_off[3])
    else $error("load did not copy input register");
  eoc_mode_a: assert property ($past(mode_r) == afd_pkg::CKM_SCLK |-> eoc_n)
    else $error("end of conversion low in mode 11");
  wake_init_a: assert property ($rose(initDone_r) |-> dacOut_r[0] == (dac_pull_ref ? 10'h3ff : 10'h000)
                                && dac_buf_off == 8'hff)
    else $error("DAC wake-up code wrong");
  osc_mode_a: assert property (int_osc_en |-> $past(mode_r) != afd_pkg::CKM_SCLK)
    else $error("oscillator on in serial-clock mode");

  temp_read_c: cover property (csFall && tempValid_r ##[1:200] csFall && resValid);
  dac_write_c: cover property (dacStb ##[1:300] dacLoad);
  gpio_write_c: cover property (gpioStb);
  overflow_c: cover property (conv_valid && !conv_ready);

endmodule

// ---- pkg/afd_pkg.sv ----
package afd_pkg;

  // ****************************************************************
  // Sizes
  // ****************************************************************
  localparam int RESULT_DEPTH = 16;
  localparam int STAGE_DEPTH  = 4;
  localparam int ADC_BITS     = 10;
  localparam int SUB_BITS     = 2;
  localparam int TEMP_BITS    = 12;
  localparam int WORD_BITS    = 16;
  localparam int DAC_CHANNELS = 8;
  localparam int DAC_BITS     = 10;
  localparam int GPIO_LINES   = 12;

  // ****************************************************************
  // Command byte decoding
  // ****************************************************************
  localparam logic [3:0] CMD_DAC_NIBBLE = 4'h1;
  localparam logic [1:0] CMD_SETUP_TOP  = 2'h1;
  localparam logic [7:0] CMD_GPIO_WRITE = 8'h02;
  localparam int         CKM_POS        = 4;

  // ****************************************************************
  // Clock modes
  // ****************************************************************
  localparam logic [1:0] CKM_CONVERT_START_N_INT = 2'h0;
  localparam logic [1:0] CKM_CONVERT_START_N_TH  = 2'h1;
  localparam logic [1:0] CKM_SERIAL    = 2'h2;
  localparam logic [1:0] CKM_SCLK      = 2'h3;
  localparam logic [1:0] CKM_RESET     = CKM_SERIAL;

  // ****************************************************************
  // DAC data word and wake-up codes
  // ****************************************************************
  localparam int         DAC_SEL_POS  = 12;
  localparam int         DAC_DATA_POS = 2;
  localparam logic [3:0] DAC_OP_LOAD  = 4'h8;
  localparam logic [3:0] DAC_OP_ALL   = 4'h9;
  localparam logic [9:0] CODE_ZERO    = 10'h000;
  localparam logic [9:0] CODE_FULL    = 10'h3ff;

  // ****************************************************************
  // Frame lengths (index of the last bit) and counter limits
  // ****************************************************************
  localparam logic [4:0] LAST_CMD_BIT   = 5'h07;
  localparam logic [4:0] LAST_SHORT_BIT = 5'h0f;
  localparam logic [4:0] LAST_LONG_BIT  = 5'h17;
  localparam logic [4:0] BIT_CNT_MAX    = 5'h1f;
  localparam logic [1:0] WAKE_SETTLE    = 2'h2;

  typedef enum logic [1:0] {FR_CMD, FR_DAC, FR_GPIO, FR_IGNORE} afd_frame_t;

endpackage

// ---- tb/afd_spi_host.sv ----
module afd_spi_host (
  input  wire logic core_clk, // Core clock
  output logic      cs_n,     // Chip select, active low
  output logic      sclk,     // Serial clock
  output logic      din,      // Data into the core
  input  wire logic dout      // Data from the core
);
  timeunit 1ns;
  timeprecision 1ps;
  // Half period in core cycles; 4 gives about 15.6 MHz, 18 stays below 3.6 MHz
  int half = 4;
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    din  = 1'b0;
  end
  // ******************************
  // Frame engine
  // ******************************
  // Clock stands still between frames; host samples just before each falling edge
  task automatic frame(input int n, input logic [23:0] tx, output logic [23:0] rx);
    rx = '0;
    @(negedge core_clk);
    cs_n = 1'b0;
    repeat (6) @(negedge core_clk);
    for (int i = n - 1; i >= 0; i--) begin
      din  = tx[i];
      sclk = 1'b1;
      repeat (half) @(negedge core_clk);
      rx   = {rx[22:0], dout};
      sclk = 1'b0;
      repeat (half) @(negedge core_clk);
    end
    cs_n = 1'b1;
    // Released line must not keep showing the last bit
    din  = ~din;
    repeat (4) @(negedge core_clk);
  endtask
endmodule

// ---- tb/tb_top.sv ----
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        core_clk = 1'b0;
  logic        resetn = 1'b0;
  logic        dac_load_strobe_n = 1'b1;
  logic        convert_start_n = 1'b1;
  logic        dac_wake_select = 1'b0;
  logic        conv_valid = 1'b0;
  logic        temp_valid = 1'b0;
  logic        ops_done = 1'b0;
  logic [11:0] conv_result = 12'h000;
  logic [11:0] temp_result = 12'h000;
  logic        cs_n, sclk, din, dout, conv_ready, eoc_n, dac_pull_ref;
  logic        clock_mode_sel_hi, clock_mode_sel_lo, int_osc_en, ext_th_en, sclk_conv_tick;
  logic [79:0] dac_code;
  logic [7:0]  dac_buf_off;
  logic [3:0]  gpio_group_a, gpio_group_b, gpio_group_c;
  logic [23:0] rx;
  int          mismatches = 0;
  int          cmp_count = 0;
  int          ticks = 0;

  always #4 core_clk = ~core_clk;
  always @(posedge core_clk) ticks <= ticks + int'(sclk_conv_tick);

  afd_core afd_core_i (.core_clk, .resetn, .cs_n, .sclk, .din, .dout, .dac_load_strobe_n,
    .convert_start_n, .dac_wake_select, .conv_valid, .conv_result, .conv_ready, .temp_valid,
    .temp_result, .ops_done, .eoc_n, .dac_code, .dac_buf_off, .dac_pull_ref, .gpio_group_a,
    .gpio_group_b, .gpio_group_c, .clock_mode_sel_hi, .clock_mode_sel_lo, .int_osc_en,
    .ext_th_en, .sclk_conv_tick);
  afd_spi_host afd_spi_host_i (.core_clk, .cs_n, .sclk, .din, .dout);

  // ******************************
  // Helpers
  // ******************************
  task automatic chk(input logic [79:0] got, input logic [79:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic stop_test();
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // Strap is held through reset and well past its capture edge
  task automatic t_wake(input logic strap);
    @(negedge core_clk);
    resetn = 1'b0;
    dac_wake_select = strap;
    repeat (3) @(negedge core_clk);
    resetn = 1'b1;
    repeat (6) @(negedge core_clk);
    chk(dac_code, {8{strap ? 10'h3ff : 10'h000}});
    chk({dac_buf_off, dac_pull_ref}, {8'hff, strap});
    chk({clock_mode_sel_hi, clock_mode_sel_lo, int_osc_en, ext_th_en, eoc_n}, 5'h15);
  endtask
  // A free edge between strobes keeps each one a clean single cycle
  task automatic push(input logic [11:0] v);
    int n = 0;
    while (conv_ready !== 1'b1 && n < 50) begin
      @(negedge core_clk);
      n++;
    end
    conv_valid = 1'b1;
    conv_result = v;
    @(negedge core_clk);
    conv_valid = 1'b0;
    @(negedge core_clk);
  endtask
  task automatic rd(input logic [15:0] exp);
    afd_spi_host_i.frame(16, 24'h0, rx);
    chk(rx[15:0], exp);
  endtask

  // ******************************
  // Scenarios
  // ******************************
  task automatic t_fifo();
    for (int i = 0; i < 18; i++) push({i[9:0], 2'b01});
    repeat (8) @(negedge core_clk);
    chk(conv_ready, 1'b1);
    for (int i = 2; i < 18; i++) rd({4'h0, i[9:0], 2'b01});
    rd(16'h0000);
  endtask
  task automatic t_temp();
    temp_result = 12'h0a8;
    temp_valid = 1'b1;
    @(negedge core_clk);
    temp_result = 12'hfec; // Minus 2.5 degrees
    @(negedge core_clk);
    temp_valid = 1'b0;
    push(12'h9a6);
    repeat (4) @(negedge core_clk);
    rd(16'h0fec);
    rd(16'h09a6);
  endtask
  task automatic t_dac();
    afd_spi_host_i.frame(24, {8'h1f, 4'h3, 10'h2a5, 2'b00}, rx);
    chk(dac_code[39:30], 10'h3ff);
    afd_spi_host_i.frame(20, {8'h10, 4'h3, 8'hff}, rx);
    @(negedge core_clk);
    dac_load_strobe_n = 1'b0;
    repeat (5) @(negedge core_clk);
    dac_load_strobe_n = 1'b1;
    chk(dac_code[39:30], 10'h2a5);
    chk(dac_buf_off, 8'h00);
    afd_spi_host_i.frame(24, {8'h10, 4'h9, 10'h155, 2'b11}, rx);
    afd_spi_host_i.frame(24, {8'h10, 4'h8, 12'h000}, rx);
    chk(dac_code, {8{10'h155}});
    afd_spi_host_i.frame(24, {8'h02, 16'h0cba}, rx);
    chk({gpio_group_c, gpio_group_b, gpio_group_a}, 12'hcba);
  endtask
  task automatic t_mode();
    int t0;
    for (int m = 0; m < 4; m++) begin
      afd_spi_host_i.frame(8, {2'b01, m[1:0], 4'h0}, rx);
      chk({clock_mode_sel_hi, clock_mode_sel_lo, int_osc_en, ext_th_en},
          {m[1:0], m != 3, m == 1});
      ops_done = 1'b1;
      @(negedge core_clk);
      ops_done = 1'b0;
      @(negedge core_clk);
      chk(eoc_n, m == 3);
      convert_start_n = 1'b0;
      repeat (4) @(negedge core_clk);
      chk(eoc_n, 1'b1);
      convert_start_n = 1'b1;
    end
    afd_spi_host_i.half = 18;
    t0 = ticks;
    afd_spi_host_i.frame(8, 24'h60, rx);
    chk(ticks - t0, 8);
    afd_spi_host_i.half = 4;
    chk({clock_mode_sel_hi, clock_mode_sel_lo}, 2'h2);
  endtask

  initial begin
    t_wake(1'b0);
    t_wake(1'b1);
    t_fifo();
    t_temp();
    t_dac();
    t_mode();
    stop_test();
  end
  // Tests need about 35 us; over ten times that means a hang
  initial begin
    #400us;
    mismatches++;
    stop_test();
  end
endmodule
